// >>> rtl/mbg_pkg.sv
// Operation
// - firmware-mode partition bounds are constants; nothing can change them
// - after reset every segment is disabled until software configures it
// - reset loads restrictive defaults; boot code completes the setup
// - segment table base pointer writes succeed only in system mode
// - memory management unit registers reachable only in system mode
// - hardware-unit registers reachable in system mode
// - user mode reaches only cpu-core registers by default
// - user mode reaches hardware-unit registers only when explicitly granted
// - only grant bits and segment attr bits are writable; other access attributes are hard-wired
// - every register has defined reset content and reset permission
// - nonvolatile read-margin control adjusts read conditions against ageing
package mbg_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [15:0] MBG_FW_LO       = 16'hf000;
  localparam logic [15:0] MBG_FW_HI       = 16'hffff;
  localparam int          MBG_SEG_N       = 8;
  localparam logic [7:0]  MBG_SFR_CORE_HI = 8'h3f;
  localparam logic [7:0]  MBG_SFR_HWU_LO  = 8'h40;
  localparam logic [7:0]  MBG_SFR_HWU_HI  = 8'h7f;
  localparam logic [7:0]  MBG_SFR_MMU_LO  = 8'h80;
  localparam logic [7:0]  MBG_SFR_TBASE   = 8'h80;
  localparam logic [7:0]  MBG_SFR_SEGBASE = 8'h90;
  localparam logic [7:0]  MBG_SFR_SEGEND  = 8'h98;
  localparam logic [7:0]  MBG_SFR_SEGATTR = 8'ha0;
  localparam logic [7:0]  MBG_SFR_UGRANT  = 8'ha8;
  localparam logic [7:0]  MBG_SFR_FGRANT  = 8'ha9;
  localparam logic [7:0]  MBG_SFR_NVMRGN  = 8'haa;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MBG_TBASE_RST   = 16'h0000;
  localparam logic [15:0] MBG_SEGB_RST    = 16'hffff;
  localparam logic [15:0] MBG_SEGE_RST    = 16'h0000;
  localparam logic [2:0]  MBG_ATTR_RST    = 3'h0;
  localparam logic [7:0]  MBG_GRANT_RST   = 8'h00;
  localparam logic [3:0]  MBG_NVM_RST     = 4'h8;

  typedef enum logic [1:0] {MBG_SYS, MBG_USR, MBG_FW, MBG_BAD} mbg_mode_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic        fetch;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbg_req_t;

  typedef struct packed {
    logic [2:0]  attr; // bit0 read, bit1 write, bit2 execute
    logic [15:0] lo;
    logic [15:0] hi;
  } mbg_seg_t;

endpackage

// >>> rtl/mbg_seg_mem.sv
`timescale 1ns/1ps
module mbg_seg_mem (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  // write port
  input  wire logic             we_in,
  input  wire logic [2:0]       widx_in,
  input  wire mbg_pkg::mbg_seg_t wdata_in,
  // registered table
  output mbg_pkg::mbg_seg_t     seg_out [mbg_pkg::MBG_SEG_N]
);
  genvar g;
  generate
    for (g = 0; g < mbg_pkg::MBG_SEG_N; g++) begin : gen_seg
      always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
          seg_out[g] <= '{mbg_pkg::MBG_ATTR_RST, mbg_pkg::MBG_SEGB_RST, mbg_pkg::MBG_SEGE_RST};
        end else if (we_in && widx_in == 3'(g)) begin
          seg_out[g] <= wdata_in;
        end
      end
    end
  endgenerate
endmodule // mbg_seg_mem

// >>> rtl/mbg_guard.sv
`timescale 1ns/1ps
module mbg_guard (
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  // cpu side
  input  wire mbg_pkg::mbg_mode_t mode_in,
  input  wire mbg_pkg::mbg_req_t  mem_req_in,
  input  wire mbg_pkg::mbg_req_t  sfr_req_in,
  // memory side
  output mbg_pkg::mbg_req_t      mem_req_out,
  // special function register side
  output mbg_pkg::mbg_req_t      sfr_req_out,
  output logic [15:0]            sfr_rdata_out,
  // status
  output logic                   violation_out,
  output logic [3:0]             nvm_margin_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mbg_pkg::mbg_req_t mem;
    mbg_pkg::mbg_req_t sfr;
    logic [15:0]       rdata;
    logic              viol;
    logic [15:0]       tbase;
    logic [7:0]        ugrant;
    logic [7:0]        fgrant;
    logic [3:0]        nvm;
  } mbg_state_t;

  mbg_state_t        st;
  mbg_state_t        next_st;
  mbg_pkg::mbg_seg_t seg [mbg_pkg::MBG_SEG_N];
  mbg_pkg::mbg_seg_t seg_wdata;
  logic              seg_we;
  logic [2:0]        seg_idx;
  localparam int     MBG_NSEG = mbg_pkg::MBG_SEG_N;
  logic [MBG_NSEG-1:0] seg_hit;

  // ----------------------------------------------------------------
  // memory check
  // ----------------------------------------------------------------
  logic fw_area;
  logic mem_ok;
  assign fw_area = mem_req_in.addr >= mbg_pkg::MBG_FW_LO;

  genvar g;
  generate
    for (g = 0; g < MBG_NSEG; g++) begin : gen_hit
      assign seg_hit[g] = mem_req_in.addr >= seg[g].lo && mem_req_in.addr <= seg[g].hi
        && (mem_req_in.fetch ? seg[g].attr[2] : (mem_req_in.we ? seg[g].attr[1] : seg[g].attr[0]));
    end
  endgenerate

  always_comb begin
    // firmware region is exclusive to firmware mode; user mode needs a segment
    unique case (mode_in)
      mbg_pkg::MBG_FW:  mem_ok = fw_area;
      mbg_pkg::MBG_SYS: mem_ok = !fw_area;
      mbg_pkg::MBG_USR: mem_ok = !fw_area && |seg_hit;
      default:          mem_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // register check
  // ----------------------------------------------------------------
  logic [7:0] sa;
  logic       is_core;
  logic       is_hwu;
  logic       is_mmu;
  logic       granted;
  logic       sfr_ok;
  logic       own;
  logic [7:0] gsel;
  assign sa      = sfr_req_in.addr[7:0];
  assign is_core = sa <= mbg_pkg::MBG_SFR_CORE_HI;
  assign is_hwu  = sa >= mbg_pkg::MBG_SFR_HWU_LO && sa <= mbg_pkg::MBG_SFR_HWU_HI;
  assign is_mmu  = sa >= mbg_pkg::MBG_SFR_MMU_LO;
  assign gsel    = (mode_in == mbg_pkg::MBG_FW) ? st.fgrant : st.ugrant;
  // one grant bit per block of eight hardware-unit registers
  assign granted = gsel[sa[5:3]];
  assign own     = is_mmu && sfr_req_in.addr[15:8] == 8'h00;

  always_comb begin
    unique case (mode_in)
      mbg_pkg::MBG_SYS: sfr_ok = 1'b1;
      mbg_pkg::MBG_USR,
      mbg_pkg::MBG_FW:  sfr_ok = is_core || (is_hwu && granted);
      default:          sfr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st           = st;
    next_st.mem       = mem_req_in;
    next_st.mem.valid = mem_req_in.valid && mem_ok;
    next_st.sfr       = sfr_req_in;
    next_st.sfr.valid = sfr_req_in.valid && sfr_ok && !own;
    next_st.viol      = (mem_req_in.valid && !mem_ok) || (sfr_req_in.valid && !sfr_ok);
    seg_we            = 1'b0;
    seg_idx           = sa[2:0];
    seg_wdata         = seg[sa[2:0]];
    if (sfr_req_in.valid && sfr_ok && own) begin
      if (sfr_req_in.we) begin
        // mmu registers only pass sfr_ok in system mode
        if (sa == mbg_pkg::MBG_SFR_TBASE) next_st.tbase = sfr_req_in.wdata;
        if (sa == mbg_pkg::MBG_SFR_UGRANT) next_st.ugrant = sfr_req_in.wdata[7:0];
        if (sa == mbg_pkg::MBG_SFR_FGRANT) next_st.fgrant = sfr_req_in.wdata[7:0];
        if (sa == mbg_pkg::MBG_SFR_NVMRGN) next_st.nvm = sfr_req_in.wdata[3:0];
        if (sa[7:3] == mbg_pkg::MBG_SFR_SEGBASE[7:3]) begin
          seg_we       = 1'b1;
          seg_wdata.lo = sfr_req_in.wdata;
        end
        if (sa[7:3] == mbg_pkg::MBG_SFR_SEGEND[7:3]) begin
          seg_we       = 1'b1;
          seg_wdata.hi = sfr_req_in.wdata;
        end
        if (sa[7:3] == mbg_pkg::MBG_SFR_SEGATTR[7:3]) begin
          seg_we         = 1'b1;
          seg_wdata.attr = sfr_req_in.wdata[2:0];
        end
      end else begin
        next_st.rdata = 16'h0000;
        if (sa == mbg_pkg::MBG_SFR_TBASE) next_st.rdata = st.tbase;
        if (sa == mbg_pkg::MBG_SFR_UGRANT) next_st.rdata = {8'h00, st.ugrant};
        if (sa == mbg_pkg::MBG_SFR_FGRANT) next_st.rdata = {8'h00, st.fgrant};
        if (sa == mbg_pkg::MBG_SFR_NVMRGN) next_st.rdata = {12'h000, st.nvm};
        if (sa[7:3] == mbg_pkg::MBG_SFR_SEGBASE[7:3]) next_st.rdata = seg[sa[2:0]].lo;
        if (sa[7:3] == mbg_pkg::MBG_SFR_SEGEND[7:3]) next_st.rdata = seg[sa[2:0]].hi;
        if (sa[7:3] == mbg_pkg::MBG_SFR_SEGATTR[7:3]) next_st.rdata = {13'h0000, seg[sa[2:0]].attr};
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st        <= '0;
      st.tbase  <= mbg_pkg::MBG_TBASE_RST;
      st.ugrant <= mbg_pkg::MBG_GRANT_RST;
      st.fgrant <= mbg_pkg::MBG_GRANT_RST;
      st.nvm    <= mbg_pkg::MBG_NVM_RST;
    end else begin
      st <= next_st;
    end
  end

  mbg_seg_mem u_seg (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .we_in      (seg_we),
    .widx_in    (seg_idx),
    .wdata_in   (seg_wdata),
    .seg_out    (seg)
  );

  assign mem_req_out    = st.mem;
  assign sfr_req_out    = st.sfr;
  assign sfr_rdata_out  = st.rdata;
  assign violation_out  = st.viol;
  assign nvm_margin_out = st.nvm;
endmodule // mbg_guard

// >>> verif/mbg_guard_chk.sv
`timescale 1ns/1ps
module mbg_guard_chk (
  // guard ports
  input wire logic               clk_sys_in,
  input wire logic               rst_in,
  input wire mbg_pkg::mbg_mode_t mode_in,
  input wire mbg_pkg::mbg_req_t  mem_req_in,
  input wire mbg_pkg::mbg_req_t  sfr_req_in,
  input wire mbg_pkg::mbg_req_t  mem_req_out,
  input wire mbg_pkg::mbg_req_t  sfr_req_out,
  input wire logic [15:0]        sfr_rdata_out,
  input wire logic               violation_out,
  input wire logic [3:0]         nvm_margin_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic sys, usr, mv, sv, own, fwa, anyv, seg_cfg;
  assign sys = mode_in == mbg_pkg::MBG_SYS;
  assign usr = mode_in == mbg_pkg::MBG_USR;
  assign mv = mem_req_in.valid;
  assign sv = sfr_req_in.valid && sfr_req_in.addr[15:8] == 8'h00;
  assign own = sv && sfr_req_in.addr[7];
  assign fwa = mem_req_in.addr >= mbg_pkg::MBG_FW_LO;
  assign anyv = mv || sfr_req_in.valid;
  // segments count as closed until system mode has written the segment block
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) seg_cfg <= 1'b0;
    else if (own && sys && sfr_req_in.we && sfr_req_in.addr[7:0] inside {[8'h90:8'ha7]}) seg_cfg <= 1'b1;
  end
  a_fw_locked:
    assert property (mv && fwa && mode_in != mbg_pkg::MBG_FW |=> !mem_req_out.valid && violation_out) else $error("fw leak");
  a_fw_open:
    assert property (mv && fwa && mode_in == mbg_pkg::MBG_FW |=> mem_req_out.valid) else $error("fw shut");
  a_seg_closed:
    assert property (!seg_cfg && mv && !fwa && usr |=> violation_out) else $error("segment open");
  a_tbase_guard:
    assert property (sv && sfr_req_in.we && sfr_req_in.addr[7:0] == 8'h80 && !sys |=> violation_out) else $error("base write");
  a_mmu_sys:
    assert property (own && sys && sfr_req_in.addr[7:0] inside {8'h80, 8'ha8, 8'haa} |=> !violation_out) else $error("own reg");
  a_hwu_sys:
    assert property (sv && !sfr_req_in.addr[7] && sys |=> sfr_req_out.valid) else $error("sys blocked");
  a_core_open:
    assert property (sv && sfr_req_in.addr[7:6] == 2'b00 && mode_in != mbg_pkg::MBG_BAD |=>
      sfr_req_out.valid && sfr_req_out.wdata == $past(sfr_req_in.wdata)) else $error("core blocked");
  a_reset_vals:
    assert property ($fell(rst_in) |-> nvm_margin_out == 4'h8 && !violation_out) else $error("reset value");
  a_bad_mode:
    assert property (anyv && mode_in == mbg_pkg::MBG_BAD |=> violation_out) else $error("bad mode");
  a_viol_cause:
    assert property (violation_out |-> $past(anyv)) else $error("stray violation");
  c_fw_deny: cover property (mv && fwa && sys);
  c_grant: cover property (sv && usr && sfr_req_in.addr[6] ##1 sfr_req_out.valid);
  c_base: cover property (own && sys && sfr_req_in.we);
endmodule // mbg_guard_chk
bind mbg_guard mbg_guard_chk u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .mode_in(mode_in),
  .mem_req_in(mem_req_in), .sfr_req_in(sfr_req_in), .mem_req_out(mem_req_out), .sfr_req_out(sfr_req_out),
  .sfr_rdata_out(sfr_rdata_out), .violation_out(violation_out), .nvm_margin_out(nvm_margin_out));

// >>> verif/mbg_sink.sv
`timescale 1ns/1ps
module mbg_sink (
  // guarded side
  input wire logic              clk_sys_in,
  input wire mbg_pkg::mbg_req_t mem_req_in,
  input wire mbg_pkg::mbg_req_t sfr_req_in,
  // count of cycles with at least one accepted request
  output int                    taken_out
);
  initial taken_out = 0;
  always @(posedge clk_sys_in) begin
    if (mem_req_in.valid === 1'b1 || sfr_req_in.valid === 1'b1) taken_out <= taken_out + 1;
  end
endmodule // mbg_sink

// >>> verif/mode_based_memory_and_sfr_guard_tb.sv
`timescale 1ns/1ps
module mode_based_memory_and_sfr_guard_tb;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  mbg_pkg::mbg_mode_t mode_in = mbg_pkg::MBG_SYS;
  mbg_pkg::mbg_req_t mem_req_in = '0, sfr_req_in = '0, mem_req_out, sfr_req_out;
  logic [15:0] sfr_rdata_out;
  logic violation_out;
  logic [3:0] nvm_margin_out;
  int fails = 0, samples_checked = 0, taken, fwd = 0, seed = 75491, r, ug = 0, fg = 0, tbase = 0, nvm = 8;
  int lo[8] = '{default: 'hffff}, hi[8] = '{default: 0}, at[8] = '{default: 0};
  always #12.5 clk_sys_in = ~clk_sys_in;
  mbg_guard DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .mode_in(mode_in), .mem_req_in(mem_req_in),
    .sfr_req_in(sfr_req_in), .mem_req_out(mem_req_out), .sfr_req_out(sfr_req_out),
    .sfr_rdata_out(sfr_rdata_out), .violation_out(violation_out), .nvm_margin_out(nvm_margin_out));
  mbg_sink u_sink (.clk_sys_in(clk_sys_in), .mem_req_in(mem_req_out), .sfr_req_in(sfr_req_out), .taken_out(taken));
  task automatic cmp(string n, logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // 0 denied, 1 forwarded, 2 taken by the guard's own registers
  function automatic int chk(int m, s, w, f, a);
    if (m == 3) return 0;
    if (!s) begin
      if (a >= 'hf000) return m == 2;
      if (m != 1) return m == 0;
      for (int i = 0; i < 8; i++) if (a >= lo[i] && a <= hi[i] && at[i][f ? 2 : w]) return 1;
      return 0;
    end
    if (a >= 'h80) return m == 0 ? 2 : 0;
    if (a < 'h40 || m == 0) return 1;
    return ((m == 1 ? ug : fg) >> a[5:3]) & 1;
  endfunction
  // expected read data of the guard's own registers other than the table base
  function automatic int own_rd(int a);
    if (a == 'ha8) return ug & 'hff;
    if (a == 'ha9) return fg & 'hff;
    if (a == 'haa) return nvm;
    if ((a >> 3) == 18) return lo[a & 7];
    if ((a >> 3) == 19) return hi[a & 7];
    if ((a >> 3) == 20) return at[a & 7] & 7;
    return 0;
  endfunction
  task automatic op(int m, s, w, f, a, d = 0);
    @(posedge clk_sys_in);
    mode_in <= mbg_pkg::mbg_mode_t'(m[1:0]);
    if (s) sfr_req_in <= {1'b1, w[0], f[0], a[15:0], d[15:0]};
    else mem_req_in <= {1'b1, w[0], f[0], a[15:0], d[15:0]};
    r = chk(m, s, w, f, a);
    @(posedge clk_sys_in);
    mem_req_in.valid <= 1'b0;
    sfr_req_in.valid <= 1'b0;
    #1;
    if (r == 2 && w) begin
      if (a == 'h80) tbase = d;
      if (a == 'ha8) ug = d;
      if (a == 'ha9) fg = d;
      if (a == 'haa) nvm = d & 15;
      if ((a >> 3) == 18) lo[a & 7] = d;
      if ((a >> 3) == 19) hi[a & 7] = d;
      if ((a >> 3) == 20) at[a & 7] = d;
    end
    cmp("violation", violation_out, r == 0);
    cmp("forward", s ? sfr_req_out.valid : mem_req_out.valid, r == 1);
    if (r == 2 && !w && a == 'h80) cmp("table base", sfr_rdata_out, tbase);
    else if (r == 2 && !w) cmp("own read", sfr_rdata_out, 16'(own_rd(a)));
    if (r == 1) cmp("forward addr", s ? sfr_req_out.addr : mem_req_out.addr, a[15:0]);
    cmp("margin", nvm_margin_out, nvm);
    fwd += (r == 1);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    op(1, 0, 0, 0, 'h1000);
    op(0, 1, 1, 0, 'h90, 'h1000);
    op(0, 1, 1, 0, 'h98, 'h1fff);
    op(0, 1, 1, 0, 'ha0, 1);
    op(1, 0, 0, 0, 'h1fff);
    op(1, 0, 0, 0, 'h2000);
    op(1, 0, 1, 0, 'h1000);
    op(1, 0, 0, 1, 'h1000);
    op(0, 0, 0, 0, 'hf000);
    op(2, 0, 0, 0, 'hffff);
    op(2, 0, 0, 0, 'h1000);
    op(3, 0, 0, 0, 'h1000);
    op(1, 1, 1, 0, 'h80, 'h1234);
    op(2, 1, 1, 0, 'h80, 'h1234);
    op(0, 1, 0, 0, 'h80);
    op(0, 1, 1, 0, 'h80, 'hbeef);
    op(0, 1, 0, 0, 'h80);
    op(1, 1, 0, 0, 'ha8);
    op(0, 1, 1, 0, 'ha8, 'h02);
    op(0, 1, 1, 0, 'ha9, 'h01);
    op(0, 1, 1, 0, 'haa, 'h3);
    op(0, 1, 0, 0, 'h98);
    op(0, 1, 0, 0, 'ha8);
    repeat (200) op($unsigned($random(seed)) % 4, 1, $random(seed) & 1, 0, $unsigned($random(seed)) % 'h80,
      $random(seed));
    // second reset in mid-run: everything must fall back to the closed defaults
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    ug = 0;
    fg = 0;
    tbase = 0;
    nvm = 8;
    lo = '{default: 'hffff};
    hi = '{default: 0};
    at = '{default: 0};
    op(0, 1, 0, 0, 'h80);
    op(0, 1, 0, 0, 'h90);
    op(1, 0, 0, 0, 'h1000);
    op(1, 1, 0, 0, 'h48);
    // the sink counts the last forwarded request one edge later
    @(posedge clk_sys_in);
    #1;
    cmp("taken", 16'(taken), 16'(fwd));
    close_out;
  end
  initial begin
    #(25 * 3000);
    fails++;
    close_out;
  end
endmodule // mode_based_memory_and_sfr_guard_tb
